/* File: logic/cspb_map.vh */
// Register offsets, field positions, reset values and modes of the codec serial pin buffer
`ifndef CSPB_MAP_VH
`define CSPB_MAP_VH

// Byte offsets on the register bus
`define CSPB_OFS_CTRL1 8'h00
`define CSPB_OFS_CTRL2 8'h04
`define CSPB_OFS_CTRL3 8'h08
`define CSPB_OFS_STATUS 8'h0c
// Buffer windows: address[7:4] selects, address[3:2] is the slot index
`define CSPB_RX_WINDOW 4'h1
`define CSPB_TX_WINDOW 4'h2

// Control one fields
`define CSPB_C1_ENABLE 0
`define CSPB_C1_BCK_DIR 1
`define CSPB_C1_FS_DIR 2
`define CSPB_C1_IDLE_MODE 3
`define CSPB_C1_MODE_HI 5
`define CSPB_C1_MODE_LO 4
// Control two fields
`define CSPB_C2_WS_HI 3
`define CSPB_C2_WS_LO 0
`define CSPB_C2_FLEN_HI 7
`define CSPB_C2_FLEN_LO 4
// Control three field
`define CSPB_C3_BCG_HI 11
`define CSPB_C3_BCG_LO 0

// Reset values
`define CSPB_RST_CTRL1 6'h00
`define CSPB_RST_WS 4'hf
`define CSPB_RST_FLEN 4'h0
`define CSPB_RST_BCG 12'h000

// Transfer formats
`define CSPB_MODE_MULTI 2'h0
`define CSPB_MODE_I2S 2'h1
`define CSPB_MODE_AC16 2'h2
`define CSPB_MODE_AC20 2'h3

// Fixed AC-Link geometry: 16 slots of 16 bits, sync high 16 periods
`define CSPB_AC_WS 4'hf
`define CSPB_AC_FLEN 4'hf
`define CSPB_LAST_SLOT 2'h3

`endif

/* File: logic/cspb_edge_sync.v */
// Two-stage synchroniser with level and edge outputs for one pin
`timescale 1ns/10ps
module cspb_edge_sync (
  input wire clk,
  input wire rstN,
  input wire din,
  output wire level,
  output wire rise,
  output wire fall
);
  reg stage1Reg;
  reg stage2Reg;
  reg stage3Reg;

  // First stage only feeds the second; edges come from stages two and three
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stage1Reg <= 1'b0;
      stage2Reg <= 1'b0;
      stage3Reg <= 1'b0;
    end else begin
      stage1Reg <= din;
      stage2Reg <= stage1Reg;
      stage3Reg <= stage2Reg;
    end
  end

  assign level = stage2Reg;
  assign rise = stage2Reg & ~stage3Reg;
  assign fall = ~stage2Reg & stage3Reg;
endmodule // cspb_edge_sync

/* File: logic/cspb_pin_buffer.v */
// Codec serial pin buffer: pins, alignment, shift register and buffers
//
// Summary of operation
// - Output direction: device drives bit clock pin
// - Enabled: data out pin is output only
// - Idle periods: data out tri-stated or low
// - Enabled: data in pin is input only
// - Frame sync pin direction follows direction bit
// - Enabled: device owns all four pin directions
// - Buffer words left-justified, MSB at 15
// - Short received words: zero unused LSBs
// - Short transmit words: unused LSBs never sent
// - One 16-bit shift register both ways
// - Words shifted MSB first
// - Word length programmable up to sixteen
// - Up to sixteen slots, 256 periods
// - Four samples buffered each direction
// - Link works on shadow copies
// - Multichannel, I2S and AC-Link formats
// - Word-size field holds length minus one
// - Disable resets counters and stops clocks
// - One 2-bit address counter for both
// - Master sync starts one period before generator wraps
`timescale 1ns/10ps
`include "cspb_map.vh"
module cspb_pin_buffer #(
  parameter ADDR_W = 8
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [ADDR_W-1:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  input wire bitClockIn,
  output reg bitClockOut,
  output reg bitClockOe,
  input wire frameSyncIn,
  output reg frameSyncOut,
  output reg frameSyncOe,
  output reg serialDataOut,
  output reg serialDataOutOe,
  input wire serialDataIn
);
  reg [1:0] rstPipe;
  wire rstIntN;
  reg [5:0] ctrl1Reg;
  reg [3:0] wordSizeReg;
  reg [3:0] frameLenReg;
  reg [11:0] bitDivReg;
  reg [15:0] rxVisible [0:3];
  reg [15:0] txVisible [0:3];
  reg [15:0] rxShadow [0:3];
  reg [15:0] txShadow [0:3];
  reg [15:0] shiftReg;
  reg [3:0] bitCnt;
  reg [3:0] slotCnt;
  reg [1:0] bufAddr;
  reg [11:0] divCnt;
  reg bclkReg;
  reg frameActive;
  reg armed;
  reg wordBusy;
  reg fsPrev;
  reg [31:0] readNext;
  wire extBclkLevel;
  wire extBclkRise;
  wire extBclkFall;
  wire fsLevel;
  wire sdiLevel;
  integer i;
  integer j;

  // Reset release through two flops
  // Entry is immediate; only the release waits for the clock
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstIntN = rstPipe[1];

  // Control decode
  wire enable = ctrl1Reg[`CSPB_C1_ENABLE];
  wire bckIsInput = ctrl1Reg[`CSPB_C1_BCK_DIR];
  wire fsIsSlave = ctrl1Reg[`CSPB_C1_FS_DIR];
  wire idleDriveLow = ctrl1Reg[`CSPB_C1_IDLE_MODE];
  wire [1:0] mode = ctrl1Reg[`CSPB_C1_MODE_HI:`CSPB_C1_MODE_LO];
  wire acLink = (mode == `CSPB_MODE_AC16) || (mode == `CSPB_MODE_AC20);
  wire i2sMode = (mode == `CSPB_MODE_I2S);
  // AC-Link geometry is fixed; field holds length minus one otherwise
  wire [3:0] wsEff = acLink ? `CSPB_AC_WS : wordSizeReg;
  wire [3:0] flenEff = acLink ? `CSPB_AC_FLEN : frameLenReg;

  // Pin inputs pass two flops before any logic reads them
  cspb_edge_sync uBclkSync (
    .clk(clk_sys),
    .rstN(rstIntN),
    .din(bitClockIn),
    .level(extBclkLevel),
    .rise(extBclkRise),
    .fall(extBclkFall)
  );
  cspb_edge_sync uFsSync (
    .clk(clk_sys),
    .rstN(rstIntN),
    .din(frameSyncIn),
    .level(fsLevel),
    .rise(),
    .fall()
  );
  cspb_edge_sync uSdiSync (
    .clk(clk_sys),
    .rstN(rstIntN),
    .din(serialDataIn),
    .level(sdiLevel),
    .rise(),
    .fall()
  );

  // Internal bit clock: half period is divider plus one system clocks
  // A zero divider or an input direction parks the internal clock
  wire genOn = enable && !bckIsInput && (bitDivReg != `CSPB_RST_BCG);
  wire divTick = genOn && (divCnt == bitDivReg);
  wire bitRise = bckIsInput ? extBclkRise : (divTick && !bclkReg);
  wire bitFall = bckIsInput ? extBclkFall : (divTick && bclkReg);

  // Position of the period that starts at the next bit clock rise
  wire wordEnd = (bitCnt == wsEff);
  wire frameLast = wordEnd && (slotCnt == flenEff);
  wire [3:0] nextBit = wordEnd ? 4'h0 : bitCnt + 4'h1;
  wire [3:0] nextSlot = wordEnd ? ((slotCnt == flenEff) ? 4'h0 : slotCnt + 4'h1) : slotCnt;
  wire nextLast = (nextBit == wsEff) && (nextSlot == flenEff);
  // I2S level follows the slot one period ahead, so it flips a period before slot 0 and before the second half
  wire [3:0] aheadSlot = (nextBit == wsEff) ?
    ((nextSlot == flenEff) ? 4'h0 : nextSlot + 4'h1) : nextSlot;
  wire [4:0] aheadTwice = {aheadSlot, 1'b0};
  wire [4:0] flenCount = {1'b0, flenEff} + 5'h01;
  reg fsMaster;

  // Master sync shape per format, taken for the coming period
  always @* begin
    case (mode)
      `CSPB_MODE_MULTI: fsMaster = nextLast;
      `CSPB_MODE_I2S: fsMaster = (aheadTwice < flenCount);
      `CSPB_MODE_AC16: fsMaster = nextLast || ((nextSlot == 4'h0) && (nextBit != wsEff));
      `CSPB_MODE_AC20: fsMaster = nextLast || ((nextSlot == 4'h0) && (nextBit != wsEff));
      default: fsMaster = 1'b0;
    endcase
  end

  // Slave start: level in framed modes, either edge in I2S
  wire fsSeen = i2sMode ? (fsLevel != fsPrev) : fsLevel;
  wire newFrame = frameLast && (!fsIsSlave || armed);
  wire newWord = frameLast ? newFrame : (frameActive && wordEnd);
  wire storeWord = wordBusy && wordEnd;
  wire [1:0] loadAddr = storeWord ? bufAddr + 2'h1 : bufAddr;
  wire swapNow = storeWord && (bufAddr == `CSPB_LAST_SLOT);
  wire [15:0] txWord = swapNow ? txVisible[loadAddr] : txShadow[loadAddr];
  // Received bits sit low; shifting up left-justifies and zero-fills
  wire [15:0] rxWord = shiftReg << (4'hf - wsEff);

  // Link side: generators, shift register, shadow buffers
  always @(posedge clk_sys or negedge rstIntN) begin
    if (!rstIntN) begin
      bitCnt <= 4'hf;
      slotCnt <= 4'hf;
      frameActive <= 1'b0;
      armed <= 1'b0;
      wordBusy <= 1'b0;
      bufAddr <= 2'h0;
      divCnt <= 12'h000;
      bclkReg <= 1'b0;
      fsPrev <= 1'b0;
      frameSyncOut <= 1'b0;
      serialDataOut <= 1'b0;
      shiftReg <= 16'h0000;
      for (i = 0; i < 4; i = i + 1) begin
        rxShadow[i] <= 16'h0000;
        txShadow[i] <= 16'h0000;
        rxVisible[i] <= 16'h0000;
      end
    end else if (!enable) begin
      // Disabled: counters back to end of frame, clocks held still
      bitCnt <= wsEff;
      slotCnt <= flenEff;
      frameActive <= 1'b0;
      armed <= 1'b0;
      wordBusy <= 1'b0;
      bufAddr <= 2'h0;
      divCnt <= 12'h000;
      bclkReg <= 1'b0;
      fsPrev <= fsLevel;
      frameSyncOut <= 1'b0;
      serialDataOut <= 1'b0;
    end else begin
      // Divider toggles the internal clock
      if (genOn) begin
        if (divTick) begin
          divCnt <= 12'h000;
          bclkReg <= ~bclkReg;
        end else begin
          divCnt <= divCnt + 12'h001;
        end
      end else begin
        divCnt <= 12'h000;
      end
      if (bitRise) begin
        fsPrev <= fsLevel;
        frameSyncOut <= fsMaster;
        // Advance word and frame counters
        if (frameLast) begin
          if (newFrame) begin
            frameActive <= 1'b1;
            bitCnt <= 4'h0;
            slotCnt <= 4'h0;
            armed <= 1'b0;
          end else begin
            frameActive <= 1'b0;
          end
        end else if (frameActive) begin
          bitCnt <= nextBit;
          slotCnt <= nextSlot;
        end
        // Idle: first sync seen arms the next frame; a pending arm is kept.
        // Active: only a sync entering the last bit arms; the rest are ignored
        if (fsIsSlave && fsSeen && (frameActive ? (nextLast && !frameLast) : !armed)) begin
          armed <= 1'b1;
        end
        // Finished word goes to its slot, then the counter moves on
        if (storeWord) begin
          rxShadow[bufAddr] <= rxWord;
          bufAddr <= bufAddr + 2'h1;
        end
        // After four words rx shadow copies to rx visible and tx visible copies to tx shadow
        if (swapNow) begin
          for (i = 0; i < 3; i = i + 1) begin
            rxVisible[i] <= rxShadow[i];
            txShadow[i] <= txVisible[i];
          end
          rxVisible[3] <= rxWord;
          txShadow[3] <= txVisible[3];
        end
        // Load next word, MSB to the pin first
        if (newWord) begin
          shiftReg <= txWord;
          serialDataOut <= txWord[15];
          wordBusy <= 1'b1;
        end else if (storeWord) begin
          serialDataOut <= 1'b0;
          wordBusy <= 1'b0;
        end else if (wordBusy) begin
          serialDataOut <= shiftReg[15];
        end
      end
      // Sample on the falling edge; only ws+1 bits ever leave the MSB end
      if (bitFall && wordBusy) begin
        shiftReg <= {shiftReg[14:0], sdiLevel};
      end
    end
  end

  // Pin directions follow the controls only while enabled; the clock pin
  // copies the next internal clock so data and clock edges leave together
  always @(posedge clk_sys or negedge rstIntN) begin
    if (!rstIntN) begin
      bitClockOut <= 1'b0;
      bitClockOe <= 1'b0;
      frameSyncOe <= 1'b0;
      serialDataOutOe <= 1'b0;
    end else begin
      bitClockOut <= enable && (divTick ? ~bclkReg : bclkReg);
      bitClockOe <= enable && !bckIsInput;
      frameSyncOe <= enable && !fsIsSlave;
      serialDataOutOe <= enable && (wordBusy || idleDriveLow);
    end
  end

  // Read mux for the bus
  always @* begin
    readNext = 32'h0000_0000;
    if (address[7:4] == `CSPB_RX_WINDOW) begin
      readNext = {16'h0000, rxVisible[address[3:2]]};
    end else if (address[7:4] == `CSPB_TX_WINDOW) begin
      readNext = {16'h0000, txVisible[address[3:2]]};
    end else begin
      case (address)
        `CSPB_OFS_CTRL1: readNext = {26'h0000000, ctrl1Reg};
        `CSPB_OFS_CTRL2: readNext = {24'h000000, frameLenReg, wordSizeReg};
        `CSPB_OFS_CTRL3: readNext = {20'h00000, bitDivReg};
        `CSPB_OFS_STATUS: readNext = {27'h0000000, fsLevel,
          (bckIsInput ? extBclkLevel : bclkReg), frameActive, bufAddr};
        default: readNext = 32'h0000_0000;
      endcase
    end
  end

  // Avalon slave: one wait cycle, write lands when waitrequest is low
  always @(posedge clk_sys or negedge rstIntN) begin
    if (!rstIntN) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
      ctrl1Reg <= `CSPB_RST_CTRL1;
      wordSizeReg <= `CSPB_RST_WS;
      frameLenReg <= `CSPB_RST_FLEN;
      bitDivReg <= `CSPB_RST_BCG;
      for (j = 0; j < 4; j = j + 1) begin
        txVisible[j] <= 16'h0000;
      end
    end else begin
      // Answer a new request once; the next edge raises waitrequest again
      if (waitrequest && (read || write)) begin
        waitrequest <= 1'b0;
        readdata <= read ? readNext : 32'h0000_0000;
      end else begin
        waitrequest <= 1'b1;
      end
      // Receive window and status are read-only, so writes there fall away
      if (write && !waitrequest) begin
        if (address[7:4] == `CSPB_TX_WINDOW) begin
          txVisible[address[3:2]] <= writedata[15:0];
        end else begin
          case (address)
            `CSPB_OFS_CTRL1: ctrl1Reg <= writedata[`CSPB_C1_MODE_HI:`CSPB_C1_ENABLE];
            `CSPB_OFS_CTRL2: begin
              wordSizeReg <= writedata[`CSPB_C2_WS_HI:`CSPB_C2_WS_LO];
              frameLenReg <= writedata[`CSPB_C2_FLEN_HI:`CSPB_C2_FLEN_LO];
            end
            `CSPB_OFS_CTRL3: bitDivReg <= writedata[`CSPB_C3_BCG_HI:`CSPB_C3_BCG_LO];
            default: ctrl1Reg <= ctrl1Reg;
          endcase
        end
      end
    end
  end
endmodule // cspb_pin_buffer

/* File: tb/cspb_monitor.sv */
// Port checker for the codec serial pin buffer
`timescale 1ns/10ps
module cspb_monitor #(
  parameter ADDR_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic bitClockIn,
  input wire logic bitClockOut,
  input wire logic bitClockOe,
  input wire logic frameSyncIn,
  input wire logic frameSyncOut,
  input wire logic frameSyncOe,
  input wire logic serialDataOut,
  input wire logic serialDataOutOe,
  input wire logic serialDataIn
);
  logic [5:0] ctl1Reg;
  logic [1:0] stabReg;
  logic mst;
  // Copy of control one; settle count hides the pin register lag
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl1Reg <= 6'h00;
      stabReg <= 2'h0;
    end else if (write && !waitrequest && address == 8'h00) begin
      ctl1Reg <= writedata[5:0];
      stabReg <= 2'h0;
    end else if (stabReg != 2'h3) begin
      stabReg <= stabReg + 2'h1;
    end
  end
  assign mst = stabReg == 2'h3 && ctl1Reg[0] && !ctl1Reg[1];
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence sAnswer;
    !waitrequest ##1 waitrequest;
  endsequence
  AST_WAIT_ANSWER: assert property ((read || write) && waitrequest |=> sAnswer)
    else $error("request not answered");
  AST_UNMAPPED_ZERO: assert property (read && !waitrequest && address == 8'h40 |-> !readdata)
    else $error("unmapped read not zero");
  AST_BCK_OE: assert property (stabReg == 2'h3 |-> bitClockOe == mst)
    else $error("bit clock enable wrong");
  AST_FS_OE: assert property (stabReg == 2'h3 |-> frameSyncOe == (ctl1Reg[0] && !ctl1Reg[2]))
    else $error("frame sync enable wrong");
  AST_PINS_OFF: assert property (stabReg == 2'h3 && !ctl1Reg[0] |-> !serialDataOutOe)
    else $error("data pin driven while off");
  AST_IDLE_DRIVE: assert property (stabReg == 2'h3 && ctl1Reg[0] && ctl1Reg[3] |-> serialDataOutOe)
    else $error("low idle mode not driving");
  AST_CLK_STOP: assert property (stabReg == 2'h3 && !ctl1Reg[0] |=> $stable(bitClockOut) && $stable(frameSyncOut))
    else $error("clocks run while off");
  AST_SDO_ON_RISE: assert property (mst && $changed(serialDataOut) |-> $rose(bitClockOut))
    else $error("data changed off a rise");
  AST_FS_ON_RISE: assert property (mst && $changed(frameSyncOut) |-> $rose(bitClockOut))
    else $error("sync changed off a rise");
endmodule // cspb_monitor
bind cspb_pin_buffer cspb_monitor #(.ADDR_W(ADDR_W)) mon (.clk_sys(clk_sys), .rst_n(rst_n),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .bitClockIn(bitClockIn),
  .bitClockOut(bitClockOut), .bitClockOe(bitClockOe), .frameSyncIn(frameSyncIn),
  .frameSyncOut(frameSyncOut), .frameSyncOe(frameSyncOe), .serialDataOut(serialDataOut),
  .serialDataOutOe(serialDataOutOe), .serialDataIn(serialDataIn));

/* File: tb/cspb_codec_model.sv */
// Behavioural codec on the far side of the serial pins
`timescale 1ns/10ps
module cspb_codec_model (
  input wire logic bckPin,
  input wire logic fsPin,
  input wire logic sdoPin,
  input wire logic sdoOe,
  input wire logic slave,
  output logic bckDrv,
  output logic fsDrv,
  output logic sdiDrv
);
  logic [3:0] rxw = 4'h0;
  logic [3:0] lastWord = 4'h0;
  logic [15:0] pat;
  logic sdoLvl;
  int k = 99;
  int per = 0;
  // Released data line shows the inverse of its last bit
  assign sdoLvl = sdoOe ? sdoPin : ~rxw[0];
  assign pat = slave ? 16'h7000 : 16'hb000;
  initial begin
    bckDrv = 1'b0;
    fsDrv = 1'b0;
    sdiDrv = 1'b0;
  end
  // Codec clock only while it is the source
  always #200 bckDrv = slave ? ~bckDrv : 1'b0;
  // Sample on fall; a sync period closes the word
  always @(negedge bckPin) begin
    rxw <= {rxw[2:0], sdoLvl};
    if (fsPin) lastWord <= {rxw[2:0], sdoLvl};
    k <= fsPin ? 0 : k + 1;
  end
  // Launch on rise, MSB first; sync in last of four periods
  always @(posedge bckPin) begin
    sdiDrv <= (k < 4) ? pat[15 - k] : ~sdiDrv;
    per <= (per + 1) % 4;
    fsDrv <= slave && per == 2;
  end
endmodule // cspb_codec_model

/* File: tb/testbench.sv */
// Self-checking bench for the codec serial pin buffer
`timescale 1ns/10ps
module testbench;
  logic clk_sys, rst_n, read, write, waitrequest, slave;
  logic [7:0] address;
  logic [31:0] writedata, readdata;
  logic bitClockOut, bitClockOe, frameSyncOut, frameSyncOe, serialDataOut, serialDataOutOe;
  wire logic bckPin, fsPin, bckDrv, fsDrv, sdiDrv;
  int num_errors = 0;
  int cmp_count = 0;
  // Pin level: enabled side drives, else the codec
  assign bckPin = bitClockOe ? bitClockOut : bckDrv;
  assign fsPin = frameSyncOe ? frameSyncOut : fsDrv;
  cspb_pin_buffer uut (.clk_sys(clk_sys), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .bitClockIn(bckPin), .bitClockOut(bitClockOut), .bitClockOe(bitClockOe),
    .frameSyncIn(fsPin), .frameSyncOut(frameSyncOut), .frameSyncOe(frameSyncOe),
    .serialDataOut(serialDataOut), .serialDataOutOe(serialDataOutOe), .serialDataIn(sdiDrv));
  cspb_codec_model codec (.bckPin(bckPin), .fsPin(fsPin), .sdoPin(serialDataOut),
    .sdoOe(serialDataOutOe), .slave(slave), .bckDrv(bckDrv), .fsDrv(fsDrv), .sdiDrv(sdiDrv));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task conclude;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Hold the request until waitrequest is seen low
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 40) begin
      num_errors++;
      $display("BAD %0t bus stuck", $time);
      conclude;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  // Reset values and an unmapped place
  task t_regs;
    rdchk(8'h00, 32'h0);
    rdchk(8'h04, 32'hf);
    rdchk(8'h40, 32'h0);
  endtask
  // Clock master, 4-bit words, short tx words
  task t_master;
    wr(8'h04, 32'h3);
    wr(8'h08, 32'h3);
    for (int i = 0; i < 4; i++) wr(8'h20 + 8'(i * 4), 32'h5fff);
    wr(8'h00, 32'h9);
    repeat (400) @(posedge clk_sys);
    for (int i = 0; i < 4; i++) rdchk(8'h10 + 8'(i * 4), 32'hb000);
    chk({28'h0, codec.lastWord}, 32'h5);
    rdchk(8'h24, 32'h5fff);
    wr(8'h10, 32'h1);
    rdchk(8'h10, 32'hb000);
  endtask
  // Codec supplies bit clock and frame sync
  task t_slave;
    wr(8'h00, 32'h0);
    slave <= 1'b1;
    wr(8'h00, 32'h7);
    repeat (800) @(posedge clk_sys);
    for (int i = 0; i < 4; i++) rdchk(8'h10 + 8'(i * 4), 32'h7000);
    chk({28'h0, codec.lastWord}, 32'h5);
    wr(8'h00, 32'h0);
  endtask
  initial begin
    rst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    slave = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_regs;
    t_master;
    t_slave;
    conclude;
  end
endmodule // testbench
